// file: core/mdsr_pkg.sv
/*
  Shared constants of the motor driver status register block: register
  indices, field positions, reset values and the
  standstill timer range.
  Assumes a 32-bit AHB-Lite bus with one aligned word per register.
*/
package mdsr_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] COMM_LIMITS_IDX = 8'h3a;
  localparam logic [7:0] DRV_STATUS_IDX  = 8'h3b;
  localparam logic [7:0] DRV_CONFIG_IDX  = 8'h30;

  // Word address width seen by the decoder
  localparam int unsigned IDX_W = 8;

  // Timing limits register fields
  localparam int unsigned SG_LIMIT_LSB = 16;
  localparam int unsigned SG_LIMIT_W   = 8;
  localparam int unsigned ONTIME_LSB   = 0;
  localparam int unsigned ONTIME_W     = 10;
  localparam int unsigned SG_SCALE_SH  = 4;  // Limit counts 16 clocks per unit

  // Driver configuration register fields
  localparam int unsigned OFFT_LSB     = 0;
  localparam int unsigned OFFT_W       = 4;
  localparam int unsigned DRV_DIS_BIT  = 4;
  localparam int unsigned STST_SEL_LSB = 8;
  localparam int unsigned STST_SEL_W   = 3;

  // Driver status register fields
  localparam int unsigned STST_BIT     = 31;
  localparam int unsigned OPEN_B_BIT   = 30;
  localparam int unsigned OPEN_A_BIT   = 29;
  localparam int unsigned SGND_B_BIT   = 28;
  localparam int unsigned SGND_A_BIT   = 27;
  localparam int unsigned OTPW_BIT     = 26;
  localparam int unsigned OVT_BIT      = 25;
  localparam int unsigned STALL_BIT    = 24;
  localparam int unsigned CS_LSB       = 16;
  localparam int unsigned CS_W         = 5;
  localparam int unsigned FULLSTEP_BIT = 15;
  localparam int unsigned QUIET_BIT    = 14;
  localparam int unsigned SSUP_B_BIT   = 13;
  localparam int unsigned SSUP_A_BIT   = 12;
  localparam int unsigned LOAD_LSB     = 0;
  localparam int unsigned LOAD_W       = 10;

  // Reset values
  localparam logic [7:0] SG_LIMIT_RST = 8'h00;
  localparam logic [9:0] ONTIME_RST   = 10'h000;
  localparam logic [3:0] OFFT_RST     = 4'h0;
  localparam logic       DRV_DIS_RST  = 1'b0;
  localparam logic [2:0] STST_SEL_RST = 3'h0;

  // Standstill timer range as powers of two of clock cycles
  localparam int unsigned STST_MIN_LOG2 = 13;
  localparam int unsigned STST_MAX_LOG2 = 20;

  // On-time counter width
  localparam int unsigned ONCNT_W = 12;

  // AHB transfer type with bit 1 set marks NONSEQ or SEQ
  localparam int unsigned HTRANS_ACT_BIT = 1;

endpackage

// file: core/mdsr_sync.sv
/*
  Three-stage synchroniser for a vector of pin inputs; a bit takes its new
  value once the second and third stages agree.
  Assumes inputs are asynchronous to hclk.
*/
`timescale 1ns/1ps
module mdsr_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_nxt;

  // Accept bits where the last two stages agree
  assign q_nxt = (s2_r & ~(s2_r ^ s3_r)) | (q & (s2_r ^ s3_r));

  // Shift chain
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q    <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q    <= q_nxt;
    end
  end

endmodule

// file: core/mdsr_stst_timer.sv
/*
  Standstill timer: raises its flag after 2^(MIN_LOG2+sel) cycles, at most 2^MAX_LOG2, without
  a step event and drops it on the next step event.
  Assumes step_evt is a one-cycle pulse on hclk.
*/
`timescale 1ns/1ps
module mdsr_stst_timer #(
  parameter int unsigned MIN_LOG2 = mdsr_pkg::STST_MIN_LOG2,
  parameter int unsigned MAX_LOG2 = mdsr_pkg::STST_MAX_LOG2
) (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Control
  input  wire logic       step_evt,
  input  wire logic [2:0] sel,
  // Result
  output logic            stst
);

  localparam int unsigned CW = MAX_LOG2 + 1;

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] lim;
  logic          reach;

  // Selected timeout, clamped to the top of the range
  assign lim   = (MIN_LOG2 + sel > MAX_LOG2) ? (CW'(1) << MAX_LOG2)
                                             : (CW'(1) << (MIN_LOG2 + sel));
  assign reach = (cnt_r + CW'(1)) >= lim;

  // Count since last step, flag when the timeout is reached
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= '0;
      stst  <= 1'b0;
    end else if (step_evt) begin
      cnt_r <= '0;
      stst  <= 1'b0;
    end else if (!stst) begin
      cnt_r <= cnt_r + CW'(1);
      stst  <= reach;
    end
  end

  step_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    step_evt |=> !stst)
    else $error("standstill flag survived a step");

endmodule

// file: core/mdsr_top.sv
/*
  Motor channel timing and driver status registers on AHB-Lite, with the
  short and overtemperature latches, the driver enable, the on-time
  limiter and the standstill timer.
  Assumes analog detector outputs arrive as asynchronous pins; pwm_on and
  const_torque_mode come from chopper logic on hclk.
*/
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
module mdsr_top #(
  parameter int unsigned STST_MIN_LOG2 = mdsr_pkg::STST_MIN_LOG2,
  parameter int unsigned STST_MAX_LOG2 = mdsr_pkg::STST_MAX_LOG2
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Chopper logic, same clock
  input  wire logic        pwm_on,
  input  wire logic        const_torque_mode,
  // Detector and motion pins, asynchronous
  input  wire logic        step_pulse,
  input  wire logic        open_load_a,
  input  wire logic        open_load_b,
  input  wire logic        short_ground_phase_a,
  input  wire logic        short_ground_phase_b,
  input  wire logic        short_supply_phase_a,
  input  wire logic        short_supply_phase_b,
  input  wire logic        overtemp_warn,
  input  wire logic        overtemp_limit,
  input  wire logic [9:0]  load_measure_result,
  input  wire logic [9:0]  coil_a_ontime,
  input  wire logic [4:0]  current_scale,
  input  wire logic        fullstep_active,
  input  wire logic        quiet_chopper_active,
  // Driver control
  output logic             driver_enable,
  output logic             commutate,
  output logic             step_loss
);

  localparam int unsigned SW = 36;
  localparam int unsigned CW = mdsr_pkg::ONCNT_W;

  // Synchronised pins
  logic [SW-1:0] pins_s;
  logic          step_s;
  logic          ol_a_s;
  logic          ol_b_s;
  logic          sg_a_s;
  logic          sg_b_s;
  logic          sv_a_s;
  logic          sv_b_s;
  logic          otpw_s;
  logic          ovt_s;
  logic [9:0]    load_s;
  logic [9:0]    coil_s;
  logic [4:0]    cs_s;
  logic          fs_s;
  logic          quiet_s;

  mdsr_sync #(.W(SW)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({step_pulse, open_load_a, open_load_b, short_ground_phase_a,
                short_ground_phase_b, short_supply_phase_a, short_supply_phase_b,
                overtemp_warn, overtemp_limit, load_measure_result, coil_a_ontime,
                current_scale, fullstep_active, quiet_chopper_active}),
    .q       (pins_s)
  );

  assign {step_s, ol_a_s, ol_b_s, sg_a_s, sg_b_s, sv_a_s, sv_b_s, otpw_s, ovt_s,
          load_s, coil_s, cs_s, fs_s, quiet_s} = pins_s;

  // Configuration and state registers
  logic [7:0]    sg_limit_r;
  logic [9:0]    ontime_limit_r;
  logic [3:0]    offt_r;
  logic          drv_dis_r;
  logic [2:0]    stst_sel_r;
  logic          sgnd_a_r;
  logic          sgnd_b_r;
  logic          ssup_a_r;
  logic          ssup_b_r;
  logic          ovt_lock_r;
  logic          step_prev_r;
  logic [CW-1:0] oncnt_r;
  logic          wr_pend_r;
  logic [7:0]    wr_idx_r;
  logic          stst;

  // Bus decode
  logic       addr_ok;
  logic [7:0] addr_idx;
  logic       wr_limits;
  logic       wr_config;
  assign addr_ok   = hsel & htrans[mdsr_pkg::HTRANS_ACT_BIT] & hready;
  assign addr_idx  = haddr[9:2];
  assign wr_limits = wr_pend_r && (wr_idx_r == mdsr_pkg::COMM_LIMITS_IDX);
  assign wr_config = wr_pend_r && (wr_idx_r == mdsr_pkg::DRV_CONFIG_IDX);

  // Next values of software registers; reads see a write in its data phase
  logic [7:0] sg_limit_nxt;
  logic [9:0] ontime_limit_nxt;
  logic [3:0] offt_nxt;
  logic       drv_dis_nxt;
  logic [2:0] stst_sel_nxt;
  assign sg_limit_nxt     = wr_limits ? hwdata[mdsr_pkg::SG_LIMIT_LSB +: 8] : sg_limit_r;
  assign ontime_limit_nxt = wr_limits ? hwdata[mdsr_pkg::ONTIME_LSB +: 10] : ontime_limit_r;
  assign offt_nxt         = wr_config ? hwdata[mdsr_pkg::OFFT_LSB +: 4] : offt_r;
  assign drv_dis_nxt      = wr_config ? hwdata[mdsr_pkg::DRV_DIS_BIT] : drv_dis_r;
  assign stst_sel_nxt     = wr_config ? hwdata[mdsr_pkg::STST_SEL_LSB +: 3] : stst_sel_r;

  // Software turning the driver off releases the short latches
  logic sw_off;
  assign sw_off = (offt_r == 4'h0) | drv_dis_r;

  // Latches: a new detection wins over the release
  logic sgnd_a_nxt;
  logic sgnd_b_nxt;
  logic ssup_a_nxt;
  logic ssup_b_nxt;
  logic ovt_lock_nxt;
  assign sgnd_a_nxt   = sg_a_s | (sgnd_a_r & ~sw_off);
  assign sgnd_b_nxt   = sg_b_s | (sgnd_b_r & ~sw_off);
  assign ssup_a_nxt   = sv_a_s | (ssup_a_r & ~sw_off);
  assign ssup_b_nxt   = sv_b_s | (ssup_b_r & ~sw_off);
  assign ovt_lock_nxt = ovt_s | (ovt_lock_r & otpw_s);

  // Driver enable; open-load flags take no part
  logic any_fault;
  logic drv_en_nxt;
  assign any_fault  = sgnd_a_r | sgnd_b_r | ssup_a_r | ssup_b_r | ovt_lock_r;
  assign drv_en_nxt = ~sw_off & ~any_fault;

  // On-time limiter and step-loss check
  logic [CW-1:0] oncnt_nxt;
  logic [CW-1:0] sg_cycles;
  logic          on_end;
  logic          commutate_nxt;
  logic          step_loss_nxt;
  assign oncnt_nxt     = !pwm_on ? '0 : (&oncnt_r) ? oncnt_r : oncnt_r + CW'(1);
  assign sg_cycles     = {sg_limit_r, 4'h0};
  assign on_end        = !pwm_on && (oncnt_r != '0);
  assign commutate_nxt = pwm_on && (ontime_limit_r != 10'h000)
                         && (oncnt_r == {2'b00, ontime_limit_r});
  assign step_loss_nxt = const_torque_mode && (sg_limit_r != 8'h00)
                         && on_end && (oncnt_r < sg_cycles);

  // Status word
  logic [9:0]  load_word;
  logic [31:0] status_word;
  assign load_word = stst ? coil_s : load_s;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[mdsr_pkg::STST_BIT]     = stst;
    status_word[mdsr_pkg::OPEN_B_BIT]   = ol_b_s;
    status_word[mdsr_pkg::OPEN_A_BIT]   = ol_a_s;
    status_word[mdsr_pkg::SGND_B_BIT]   = sgnd_b_r;
    status_word[mdsr_pkg::SGND_A_BIT]   = sgnd_a_r;
    status_word[mdsr_pkg::OTPW_BIT]     = otpw_s;
    status_word[mdsr_pkg::OVT_BIT]      = ovt_lock_r;
    status_word[mdsr_pkg::STALL_BIT]    = (load_word == 10'h000);
    status_word[mdsr_pkg::CS_LSB +: 5]  = cs_s;
    status_word[mdsr_pkg::FULLSTEP_BIT] = fs_s;
    status_word[mdsr_pkg::QUIET_BIT]    = quiet_s;
    status_word[mdsr_pkg::SSUP_B_BIT]   = ssup_b_r;
    status_word[mdsr_pkg::SSUP_A_BIT]   = ssup_a_r;
    status_word[mdsr_pkg::LOAD_LSB +: 10] = load_word;
  end

  // Read mux; unmapped words read zero
  logic [31:0] limits_word;
  logic [31:0] config_word;
  logic [31:0] rd_word;
  assign limits_word = {8'h00, sg_limit_nxt, 6'h00, ontime_limit_nxt};
  assign config_word = {21'h000000, stst_sel_nxt, 3'h0, drv_dis_nxt, offt_nxt};
  assign rd_word = (addr_idx == mdsr_pkg::COMM_LIMITS_IDX) ? limits_word :
                   (addr_idx == mdsr_pkg::DRV_STATUS_IDX)  ? status_word :
                   (addr_idx == mdsr_pkg::DRV_CONFIG_IDX)  ? config_word : 32'h0000_0000;

  mdsr_stst_timer #(
    .MIN_LOG2 (STST_MIN_LOG2),
    .MAX_LOG2 (STST_MAX_LOG2)
  ) u_stst (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .step_evt (step_s & ~step_prev_r),
    .sel      (stst_sel_r),
    .stst     (stst)
  );

  // Bus side registers; status writes fall through with no target
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend_r <= addr_ok & hwrite;
      wr_idx_r  <= addr_idx;
      hrdata    <= (addr_ok & ~hwrite) ? rd_word : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Software registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sg_limit_r     <= mdsr_pkg::SG_LIMIT_RST;
      ontime_limit_r <= mdsr_pkg::ONTIME_RST;
      offt_r         <= mdsr_pkg::OFFT_RST;
      drv_dis_r      <= mdsr_pkg::DRV_DIS_RST;
      stst_sel_r     <= mdsr_pkg::STST_SEL_RST;
    end else begin
      sg_limit_r     <= sg_limit_nxt;
      ontime_limit_r <= ontime_limit_nxt;
      offt_r         <= offt_nxt;
      drv_dis_r      <= drv_dis_nxt;
      stst_sel_r     <= stst_sel_nxt;
    end
  end

  // Fault latches and driver outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sgnd_a_r      <= 1'b0;
      sgnd_b_r      <= 1'b0;
      ssup_a_r      <= 1'b0;
      ssup_b_r      <= 1'b0;
      ovt_lock_r    <= 1'b0;
      step_prev_r   <= 1'b0;
      oncnt_r       <= '0;
      driver_enable <= 1'b0;
      commutate     <= 1'b0;
      step_loss     <= 1'b0;
    end else begin
      sgnd_a_r      <= sgnd_a_nxt;
      sgnd_b_r      <= sgnd_b_nxt;
      ssup_a_r      <= ssup_a_nxt;
      ssup_b_r      <= ssup_b_nxt;
      ovt_lock_r    <= ovt_lock_nxt;
      step_prev_r   <= step_s;
      oncnt_r       <= oncnt_nxt;
      driver_enable <= drv_en_nxt;
      commutate     <= commutate_nxt;
      step_loss     <= step_loss_nxt;
    end
  end

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  short_hold_a: assert property (sgnd_a_r && !sw_off |=> sgnd_a_r)
    else $error("short latch dropped while driver still on");
  short_set_a: assert property (sv_b_s |=> ssup_b_r ##1 !driver_enable)
    else $error("short to supply did not latch and disable");
  ground_off_a: assert property (sg_b_s |=> sgnd_b_r ##1 !driver_enable)
    else $error("short to ground did not latch and disable");
  ovt_hold_a: assert property (ovt_lock_r && otpw_s |=> ovt_lock_r ##1 !driver_enable)
    else $error("overtemperature lock released too early");
  stall_flag_a: assert property (status_word[24] == (status_word[9:0] == 10'h000))
    else $error("stall flag does not match load result");
  commut_time_a: assert property (commutate |-> $past(pwm_on)
                                  && $past(oncnt_r) == {2'b00, $past(ontime_limit_r)})
    else $error("commutation not at on-time limit");
  step_loss_a: assert property (step_loss |-> $past(const_torque_mode)
                                && $past(sg_limit_r) != 8'h00
                                && $past(oncnt_r) < {$past(sg_limit_r), 4'h0})
    else $error("step loss outside enabled window");
  status_ro_a: assert property (wr_pend_r && wr_idx_r == mdsr_pkg::DRV_STATUS_IDX
                                |=> $stable(sg_limit_r) && $stable(offt_r)
                                && $stable(ontime_limit_r))
    else $error("status write changed a register");
  openload_free_a: assert property ((ol_a_s || ol_b_s) && !any_fault && !sw_off
                                    |=> driver_enable)
    else $error("open load affected the driver");

endmodule

// file: tb/mdsr_tb.sv
/*
  Self-checking bench for the motor status register block: bus access,
  short and overtemperature latches, on-time limiter and standstill flag.
  Assumes the bench drives every pin itself on one 125 MHz clock and
  shortens the standstill timer through the top parameters.
*/
`timescale 1ns/1ps
module tb;
  localparam logic [31:0] LIM_A = {22'h0, mdsr_pkg::COMM_LIMITS_IDX, 2'b00};
  localparam logic [31:0] STA_A = {22'h0, mdsr_pkg::DRV_STATUS_IDX, 2'b00};
  localparam logic [31:0] CFG_A = {22'h0, mdsr_pkg::DRV_CONFIG_IDX, 2'b00};

  // Clock, reset and bus
  logic        hclk;
  logic        hresetn;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [1:0]  htrans;
  logic        hwrite;
  logic        hreadyout;
  logic        hresp;
  // Pins and results
  logic        pwm_on;
  logic        ctm;
  logic        step_pulse;
  logic        moving;
  logic [2:0]  stp_cnt;
  logic [1:0]  open_load;
  logic [3:0]  shorts;
  logic        ovt_warn;
  logic        ovt_limit;
  logic [9:0]  load;
  logic [9:0]  coil;
  logic [4:0]  cs;
  logic        fs;
  logic        quiet;
  logic        driver_enable;
  logic        commutate;
  logic        step_loss;
  int          bad_count;
  int          checks;

  // Short standstill timer: 2^(4+sel) cycles, at most 2^6
  mdsr_top #(.STST_MIN_LOG2(4), .STST_MAX_LOG2(6)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pwm_on(pwm_on),
    .const_torque_mode(ctm), .step_pulse(step_pulse), .open_load_a(open_load[0]),
    .open_load_b(open_load[1]), .short_ground_phase_a(shorts[1]),
    .short_ground_phase_b(shorts[0]), .short_supply_phase_a(shorts[3]),
    .short_supply_phase_b(shorts[2]), .overtemp_warn(ovt_warn),
    .overtemp_limit(ovt_limit), .load_measure_result(load), .coil_a_ontime(coil),
    .current_scale(cs), .fullstep_active(fs), .quiet_chopper_active(quiet),
    .driver_enable(driver_enable), .commutate(commutate), .step_loss(step_loss));

  // Clock generator
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // Step pulses every 8 cycles while moving
  always @(posedge hclk) begin
    if (!hresetn) begin
      stp_cnt    <= 3'h0;
      step_pulse <= 1'b0;
    end else if (moving) begin
      stp_cnt    <= stp_cnt + 3'h1;
      step_pulse <= stp_cnt[2];
    end
  end

  // Report, verdict and end of run
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait for hready at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 100) begin
        check({31'h0, hreadyout}, 32'h1);
        give_verdict();
      end
      @(posedge hclk);
    end
  endtask

  // One single AHB-Lite transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(x & m, e);
  endtask

  // Cycles from pwm_on rising to the first commutate pulse, 0 if none
  task automatic t_commute(input logic [9:0] lim, input int exp);
    int first;
    first = 0;
    wr(LIM_A, {22'h0, lim});
    pwm_on <= 1'b1;
    for (int n = 1; n < lim + 10; n++) begin
      @(posedge hclk);
      #1;
      if (commutate === 1'b1 && first == 0) begin
        first = n;
      end
    end
    @(posedge hclk);
    pwm_on <= 1'b0;
    check(32'(first), 32'(exp));
    repeat (4) @(posedge hclk);
  endtask

  // Step-loss pulses seen after an on-phase of on_len cycles in mode ct
  task automatic t_sloss(input logic [7:0] sg, input int on_len, input logic ct,
                         input int exp);
    int hits;
    hits = 0;
    wr(LIM_A, {8'h0, sg, 16'h000e});
    ctm    <= ct;
    pwm_on <= 1'b1;
    repeat (on_len) @(posedge hclk);
    pwm_on <= 1'b0;
    repeat (12) begin
      @(posedge hclk);
      #1;
      if (step_loss === 1'b1) begin
        hits++;
      end
    end
    @(posedge hclk);
    ctm <= 1'b0;
    check(32'(hits), 32'(exp));
  endtask

  // Each short pin latches its flag and stops the driver until cleared
  task automatic t_shorts;
    logic [31:0] bitpos [4];
    bitpos = '{32'h1000_0000, 32'h0800_0000, 32'h0000_2000, 32'h0000_1000};
    for (int i = 0; i < 4; i++) begin
      wr(CFG_A, 32'h0000_0001);
      repeat (3) @(posedge hclk);
      check({31'h0, driver_enable}, 32'h1);
      shorts <= 4'h1 << i;
      repeat (8) @(posedge hclk);
      shorts <= 4'h0;
      repeat (8) @(posedge hclk);
      check({31'h0, driver_enable}, 32'h0);
      rd_chk(STA_A, 32'h1800_3000, bitpos[i]);
      wr(CFG_A, (i % 2 == 0) ? 32'h0000_0000 : 32'h0000_0011);
      repeat (2) @(posedge hclk);
      rd_chk(STA_A, 32'h1800_3000, 32'h0);
    end
  endtask

  // Shutdown holds the driver off until the prewarning also drops
  task automatic t_overtemp;
    wr(CFG_A, 32'h0000_0001);
    ovt_warn  <= 1'b1;
    ovt_limit <= 1'b1;
    repeat (8) @(posedge hclk);
    ovt_limit <= 1'b0;
    repeat (8) @(posedge hclk);
    check({31'h0, driver_enable}, 32'h0);
    rd_chk(STA_A, 32'h0600_0000, 32'h0600_0000);
    ovt_warn <= 1'b0;
    repeat (8) @(posedge hclk);
    check({31'h0, driver_enable}, 32'h1);
    rd_chk(STA_A, 32'h0600_0000, 32'h0);
    wr(CFG_A, 32'h0000_0000);
  endtask

  // Status fields, stall and standstill load source
  task automatic t_status;
    wr(CFG_A, 32'h0000_0001);
    open_load <= 2'b01;
    fs        <= 1'b1;
    cs        <= 5'h15;
    coil      <= 10'h2a5;
    load      <= 10'h133;
    repeat (30) @(posedge hclk);
    rd_chk(STA_A, 32'hffff_ffff, 32'ha015_82a5);
    open_load <= 2'b10;
    fs        <= 1'b0;
    quiet     <= 1'b1;
    cs        <= 5'h0a;
    coil      <= 10'h000;
    repeat (8) @(posedge hclk);
    wr(STA_A, 32'hffff_ffff);
    rd_chk(STA_A, 32'hffff_ffff, 32'hc10a_4000);
    moving <= 1'b1;
    repeat (30) @(posedge hclk);
    rd_chk(STA_A, 32'hffff_ffff, 32'h400a_4133);
    check({31'h0, driver_enable}, 32'h1);
    moving <= 1'b0;
    open_load <= 2'b00;
    quiet     <= 1'b0;
    wr(CFG_A, 32'h0000_0000);
  endtask

  // Standstill after 2^5 cycles with select 1
  task automatic t_stst;
    wr(CFG_A, 32'h0000_0100);
    moving <= 1'b1;
    repeat (20) @(posedge hclk);
    moving <= 1'b0;
    repeat (20) @(posedge hclk);
    rd_chk(STA_A, 32'h8000_0000, 32'h0);
    repeat (30) @(posedge hclk);
    rd_chk(STA_A, 32'h8000_0000, 32'h8000_0000);
    wr(CFG_A, 32'h0000_0000);
  endtask

  // Main sequence
  initial begin
    bad_count = 0;
    checks = 0;
    hresetn = 1'b0;
    {haddr, hwdata, htrans, hwrite} = '0;
    {pwm_on, ctm, moving, open_load, shorts} = '0;
    {ovt_warn, ovt_limit, load, coil, cs, fs, quiet} = '0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check({31'h0, driver_enable}, 32'h0);
    rd_chk(LIM_A, 32'hffff_ffff, 32'h0);
    wr(LIM_A, 32'h00ab_02c3);
    rd_chk(LIM_A, 32'hffff_ffff, 32'h00ab_02c3);
    wr(LIM_A, 32'hffff_ffff);
    rd_chk(LIM_A, 32'hffff_ffff, 32'h00ff_03ff);
    wr(32'h0000_0004, 32'h1234_5678);
    rd_chk(32'h0000_0004, 32'hffff_ffff, 32'h0);
    rd_chk(LIM_A, 32'hffff_ffff, 32'h00ff_03ff);
    t_commute(10'h005, 6);
    t_commute(10'h000, 0);
    t_sloss(8'h01, 4, 1'b1, 1);
    t_sloss(8'h01, 20, 1'b1, 0);
    t_sloss(8'h00, 4, 1'b1, 0);
    t_sloss(8'h01, 4, 1'b0, 0);
    t_status();
    t_shorts();
    t_overtemp();
    t_stst();
    give_verdict();
  end
endmodule
